//--- design/sbx_consts.svh
// Offsets, field positions, codes and constants of the shift/decimal/dispatch unit
`ifndef SBX_CONSTS_SVH
`define SBX_CONSTS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SBX_ADDR_AC0 12'h000
`define SBX_ADDR_AC1 12'h004
`define SBX_ADDR_AC2 12'h008
`define SBX_ADDR_AC3 12'h00C
`define SBX_ADDR_STAT 12'h010
`define SBX_ADDR_PC 12'h014
`define SBX_ADDR_EA 12'h018
`define SBX_ADDR_INSTR 12'h01C
`define SBX_ADDR_CMD 12'h020
`define SBX_ADDR_BLOW 12'h024
`define SBX_ADDR_BHIGH 12'h028
`define SBX_ADDR_BENTRY 12'h02C
`define SBX_ADDR_BCOUNT 12'h030
`define SBX_ADDR_P31 12'h034
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SBX_ST_CARRY 0
`define SBX_ST_BUSY 1
`define SBX_ST_HALT 2
`define SBX_ST_BAD 3
`define SBX_CMD_OP 3:0
`define SBX_CMD_ACS 5:4
`define SBX_CMD_ACD 7:6
`define SBX_CMD_FUNC 9:8
`define SBX_CMD_DEV 15:10
`define SBX_BMC_DIR_BIT 15
`define SBX_IND_BIT 15
// ----------------------------------------------------------------
// Codes and constants
// ----------------------------------------------------------------
`define SBX_DOUBLE_LOGICAL_SHIFT_OP_PAT 11'h2C8
`define SBX_DEV_CPU 6'h3F
`define SBX_DEV_BMC 6'h05
`define SBX_DEV_MAP 6'h0C
`define SBX_NO_ENTRY 16'hFFFF
`define SBX_LIM_LO_OFS 16'h0002
`define SBX_LIM_HI_OFS 16'h0001
`define SBX_STEP 16'h0001
`define SBX_SKIP 16'h0002
`define SBX_BCD_RADIX 4'hA
`define SBX_SHIFT_MAX 8'h1F
`endif

//--- design/sbx_pkg.sv
// Types shared by the shift/decimal/dispatch unit
package sbx_pkg;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_DOUBLE_LOGICAL_SHIFT_OP = 4'h1, OP_DOA = 4'h2, OP_DOB = 4'h3, OP_DOC = 4'h4,
    OP_DSB = 4'h5, OP_TABLE_DISPATCH_OP = 4'h6, OP_DSZ = 4'h7, OP_EXTENDED_DECREMENT_SKIP_ZERO_OP = 4'h8
  } sbx_op_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_EXEC = 3'b001, ST_RD_LO = 3'b010, ST_RD_HI = 3'b011,
    ST_RD_TAB = 3'b100, ST_RD_IND = 3'b101, ST_DEC_RD = 3'b110, ST_DEC_WR = 3'b111
  } sbx_state_type;
endpackage

//--- design/sbx_mem_if.sv
// Request/answer carrier between the sequencer and the memory port
`timescale 1ns/1ps
interface sbx_mem_if;
  logic start;
  logic we;
  logic lock;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic done;
  modport ctl (output start, we, lock, addr, wdata, input rdata, done);
  modport port (input start, we, lock, addr, wdata, output rdata, done);
endinterface

//--- design/sbx_alu.sv
// Double logical shift and single-digit decimal subtract datapath
`timescale 1ns/1ps
`include "sbx_consts.svh"
module sbx_alu (
  input wire logic [15:0] acs_val,
  input wire logic [15:0] acd_val,
  input wire logic [15:0] acn_val,
  input wire logic carry,
  output logic [15:0] shift_hi,
  output logic [15:0] shift_lo,
  output logic [3:0] bcd_digit,
  output logic bcd_carry
);
  logic signed [7:0] cnt;
  logic [7:0] mag;
  logic [31:0] opnd;
  logic [31:0] res;
  logic [5:0] diff;

  assign cnt = $signed(acs_val[7:0]);
  assign mag = cnt[7] ? 8'(-cnt) : 8'(cnt);
  assign opnd = {acd_val, acn_val};
  assign res = cnt[7] ? (opnd >> mag[4:0]) : (opnd << mag[4:0]);

  always_comb begin
    if (mag > `SBX_SHIFT_MAX) begin
      shift_hi = 16'h0000;
      shift_lo = acn_val;
    end else begin
      shift_hi = res[31:16];
      shift_lo = res[15:0];
    end
  end

  assign diff = {2'b00, acd_val[3:0]} - {2'b00, acs_val[3:0]} - {5'b0_0000, ~carry};
  assign bcd_digit = diff[5] ? 4'(diff[3:0] + `SBX_BCD_RADIX) : diff[3:0];
  assign bcd_carry = ~diff[5];
endmodule // sbx_alu

//--- design/sbx_mem_port.sv
// Memory port: holds one request until acknowledged, keeps the lock line
`timescale 1ns/1ps
module sbx_mem_port (
  input wire logic clk,
  input wire logic rst_n,
  sbx_mem_if.port mi,
  output logic mem_req,
  output logic mem_we,
  output logic mem_lock,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack
);
  logic done_r;
  logic [15:0] rdata_r;

  assign mi.done = done_r;
  assign mi.rdata = rdata_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_lock <= 1'b0;
    end else begin
      mem_lock <= mi.lock;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      rdata_r <= 16'h0000;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (mi.start) begin
        mem_req <= 1'b1;
        mem_we <= mi.we;
        mem_addr <= mi.addr;
        mem_wdata <= mi.wdata;
      end else if (mem_req && mem_ack) begin
        mem_req <= 1'b0;
        rdata_r <= mem_rdata;
        done_r <= 1'b1;
      end
    end
  end
endmodule // sbx_mem_port

//--- design/sbx_exec_unit.sv
// Execution unit for shift, decimal subtract, output transfers, dispatch, decrement-skip
// Notes on behaviour
// - Shift count is signed bits 0-7 of source; positive left, negative right.
// - Shift operand is destination and next accumulator; three wraps to zero.
// - Shift by count magnitude, zero fill, lost bits dropped, source kept.
// - Count magnitude above 31 clears destination; carry and source kept.
// - Output A copies accumulator to device A buffer, then function on flags.
// - Outputs B and C copy accumulator to matching buffer, function on flags.
// - Output C of accumulator zero to processor code halts execution.
// - Output A to burst channel loads low start address.
// - Output B to burst channel sets direction/high address or first entry.
// - Output C to burst channel sets map entry count.
// - Output B to translator sets physical page for page 31.
// - Decimal subtract low digits with inverted carry, result into low digit.
// - Carry is inverted borrow; source and upper destination bits kept.
// - Dispatch reads lower then upper signed limit ahead of table.
// - Value outside limits falls through to next instruction.
// - Within limits, read table word at address minus lower plus value.
// - All-ones entry falls through; else follow indirection and jump.
// - Decrement-skip reads word, writes it minus one, skips on zero.
`timescale 1ns/1ps
`include "sbx_consts.svh"
module sbx_exec_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic mem_we,
  output logic mem_lock,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic io_strobe,
  output logic [1:0] io_buf,
  output logic [5:0] io_dev,
  output logic [1:0] io_func,
  output logic [15:0] io_data,
  output logic halted
);
  import sbx_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] ac_r [4];
  logic carry_r;
  logic bad_r;
  logic [15:0] pc_r;
  logic [15:0] ea_r;
  logic [15:0] instr_r;
  sbx_op_type op_r;
  logic [1:0] cacs_r;
  logic [1:0] cacd_r;
  logic [1:0] func_r;
  logic [5:0] dev_r;
  logic [15:0] blow_r;
  logic [15:0] bhigh_r;
  logic [15:0] bentry_r;
  logic [15:0] bcount_r;
  logic [15:0] p31_r;
  sbx_state_type st_r;
  logic [15:0] lim_lo_r;
  logic dec_zero_r;
  logic lock_r;
  logic ms_start_r;
  logic ms_we_r;
  logic [15:0] ms_addr_r;
  logic [15:0] ms_wdata_r;

  sbx_mem_if mi ();

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic apb_wr;
  logic apb_idle_wr;
  logic rd_hit;
  logic [31:0] rd_data;

  // Writes land only on the edge that completes the access
  assign apb_wr = psel && penable && pready && pwrite;
  // Busy unit (sequencer out of idle) ignores accumulator, carry and command writes so operands cannot move mid-flight
  assign apb_idle_wr = apb_wr && (st_r == ST_IDLE);

  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr)
      `SBX_ADDR_AC0: rd_data = {16'h0000, ac_r[0]};
      `SBX_ADDR_AC1: rd_data = {16'h0000, ac_r[1]};
      `SBX_ADDR_AC2: rd_data = {16'h0000, ac_r[2]};
      `SBX_ADDR_AC3: rd_data = {16'h0000, ac_r[3]};
      `SBX_ADDR_STAT: rd_data = {28'h000_0000, bad_r, halted, (st_r != ST_IDLE), carry_r};
      `SBX_ADDR_PC: rd_data = {16'h0000, pc_r};
      `SBX_ADDR_EA: rd_data = {16'h0000, ea_r};
      `SBX_ADDR_INSTR: rd_data = {16'h0000, instr_r};
      `SBX_ADDR_CMD: rd_data = {16'h0000, dev_r, func_r, cacd_r, cacs_r, op_r};
      `SBX_ADDR_BLOW: rd_data = {16'h0000, blow_r};
      `SBX_ADDR_BHIGH: rd_data = {16'h0000, bhigh_r};
      `SBX_ADDR_BENTRY: rd_data = {16'h0000, bentry_r};
      `SBX_ADDR_BCOUNT: rd_data = {16'h0000, bcount_r};
      `SBX_ADDR_P31: rd_data = {16'h0000, p31_r};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      prdata <= (psel && penable && !pready && !pwrite) ? rd_data : 32'h0000_0000;
      pslverr <= psel && penable && !pready && !rd_hit;
    end
  end

  // ----------------------------------------------------------------
  // Operand selection
  // ----------------------------------------------------------------
  logic double_logical_shift_op_hit;
  logic [1:0] sel_s;
  logic [1:0] sel_d;
  logic [1:0] sel_n;
  logic [15:0] acv;
  logic [15:0] sh_hi;
  logic [15:0] sh_lo;
  logic [3:0] bcd_dig;
  logic bcd_cy;
  logic exec;
  logic out_op;
  logic halt_cmd;
  logic bmc_hit;
  logic map_hit;

  assign double_logical_shift_op_hit = instr_r[15] && (instr_r[10:0] == `SBX_DOUBLE_LOGICAL_SHIFT_OP_PAT);
  assign sel_s = (op_r == OP_DOUBLE_LOGICAL_SHIFT_OP) ? instr_r[14:13] : cacs_r;
  assign sel_d = (op_r == OP_DOUBLE_LOGICAL_SHIFT_OP) ? instr_r[12:11] : cacd_r;
  assign sel_n = 2'(sel_d + 2'b01);
  assign acv = ac_r[sel_d];
  assign exec = (st_r == ST_EXEC);
  assign out_op = (op_r == OP_DOA) || (op_r == OP_DOB) || (op_r == OP_DOC);
  assign halt_cmd = (op_r == OP_DOC) && (dev_r == `SBX_DEV_CPU) && (cacd_r == 2'b00);
  assign bmc_hit = dev_r == `SBX_DEV_BMC;
  assign map_hit = (dev_r == `SBX_DEV_MAP) && (op_r == OP_DOB);

  sbx_alu u_alu (
    .acs_val(ac_r[sel_s]),
    .acd_val(ac_r[sel_d]),
    .acn_val(ac_r[sel_n]),
    .carry(carry_r),
    .shift_hi(sh_hi),
    .shift_lo(sh_lo),
    .bcd_digit(bcd_dig),
    .bcd_carry(bcd_cy)
  );

  // ----------------------------------------------------------------
  // Accumulators, carry and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ac_r[0] <= 16'h0000;
      ac_r[1] <= 16'h0000;
      ac_r[2] <= 16'h0000;
      ac_r[3] <= 16'h0000;
    end else if (exec && (op_r == OP_DOUBLE_LOGICAL_SHIFT_OP) && double_logical_shift_op_hit) begin
      // shifted pair written back, source untouched
      ac_r[sel_d] <= sh_hi;
      ac_r[sel_n] <= sh_lo;
    end else if (exec && (op_r == OP_DSB)) begin
      ac_r[sel_d] <= {ac_r[sel_d][15:4], bcd_dig};
    end else if (apb_idle_wr && (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'b00)) begin
      ac_r[paddr[3:2]] <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      carry_r <= 1'b0;
    end else if (exec && (op_r == OP_DSB)) begin
      carry_r <= bcd_cy;
    end else if (apb_idle_wr && (paddr == `SBX_ADDR_STAT)) begin
      carry_r <= pwdata[`SBX_ST_CARRY];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bad_r <= 1'b0;
    end else if (exec && (op_r == OP_DOUBLE_LOGICAL_SHIFT_OP) && !double_logical_shift_op_hit) begin
      bad_r <= 1'b1;
    end else if (apb_wr && (paddr == `SBX_ADDR_STAT) && pwdata[`SBX_ST_BAD]) begin
      bad_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      halted <= 1'b0;
    end else if (exec && halt_cmd) begin
      halted <= 1'b1;
    end else if (apb_wr && (paddr == `SBX_ADDR_STAT)) begin
      halted <= pwdata[`SBX_ST_HALT];
    end
  end

  // ----------------------------------------------------------------
  // Command and operand registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ea_r <= 16'h0000;
      instr_r <= 16'h0000;
      op_r <= OP_NONE;
      cacs_r <= 2'b00;
      cacd_r <= 2'b00;
      func_r <= 2'b00;
      dev_r <= 6'h00;
    end else if (apb_idle_wr) begin
      if (paddr == `SBX_ADDR_EA) begin
        ea_r <= pwdata[15:0];
      end
      if (paddr == `SBX_ADDR_INSTR) begin
        instr_r <= pwdata[15:0];
      end
      if (paddr == `SBX_ADDR_CMD) begin
        op_r <= sbx_op_type'(pwdata[`SBX_CMD_OP]);
        cacs_r <= pwdata[`SBX_CMD_ACS];
        cacd_r <= pwdata[`SBX_CMD_ACD];
        func_r <= pwdata[`SBX_CMD_FUNC];
        dev_r <= pwdata[`SBX_CMD_DEV];
      end
    end
  end

  // ----------------------------------------------------------------
  // Burst channel and translator targets
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      blow_r <= 16'h0000;
      bhigh_r <= 16'h0000;
      bentry_r <= 16'h0000;
      bcount_r <= 16'h0000;
      p31_r <= 16'h0000;
    end else if (exec && bmc_hit) begin
      if (op_r == OP_DOA) begin
        blow_r <= acv;
      end
      // top bit picks direction/high address or first entry
      if (op_r == OP_DOB && acv[`SBX_BMC_DIR_BIT]) begin
        bhigh_r <= acv;
      end
      if (op_r == OP_DOB && !acv[`SBX_BMC_DIR_BIT]) begin
        bentry_r <= acv;
      end
      if (op_r == OP_DOC) begin
        bcount_r <= acv;
      end
    end else if (exec && map_hit) begin
      p31_r <= acv;
    end
  end

  // ----------------------------------------------------------------
  // I/O bus output transfers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      io_strobe <= 1'b0;
      io_buf <= 2'b00;
      io_dev <= 6'h00;
      io_func <= 2'b00;
      io_data <= 16'h0000;
    end else begin
      io_strobe <= 1'b0;
      // accumulator to buffer A/B/C, function with it
      if (exec && out_op && !halt_cmd && !bmc_hit && !map_hit) begin
        io_strobe <= 1'b1;
        io_buf <= 2'(op_r - OP_DOA);
        io_dev <= dev_r;
        io_func <= func_r;
        io_data <= acv;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign mi.start = ms_start_r;
  assign mi.we = ms_we_r;
  assign mi.lock = lock_r;
  assign mi.addr = ms_addr_r;
  assign mi.wdata = ms_wdata_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      pc_r <= 16'h0000;
      lim_lo_r <= 16'h0000;
      dec_zero_r <= 1'b0;
      lock_r <= 1'b0;
      ms_start_r <= 1'b0;
      ms_we_r <= 1'b0;
      ms_addr_r <= 16'h0000;
      ms_wdata_r <= 16'h0000;
    end else begin
      ms_start_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (apb_wr && (paddr == `SBX_ADDR_CMD) && !halted) begin
            st_r <= ST_EXEC;
          end else if (apb_wr && (paddr == `SBX_ADDR_PC)) begin
            pc_r <= pwdata[15:0];
          end
        end
        ST_EXEC: begin
          if (op_r == OP_TABLE_DISPATCH_OP) begin
            st_r <= ST_RD_LO;
            ms_start_r <= 1'b1;
            ms_we_r <= 1'b0;
            ms_addr_r <= ea_r - `SBX_LIM_LO_OFS;
          end else if (op_r == OP_DSZ || op_r == OP_EXTENDED_DECREMENT_SKIP_ZERO_OP) begin
            st_r <= ST_DEC_RD;
            lock_r <= 1'b1;
            ms_start_r <= 1'b1;
            ms_we_r <= 1'b0;
            ms_addr_r <= ea_r;
          end else begin
            st_r <= ST_IDLE;
            pc_r <= pc_r + `SBX_STEP;
          end
        end
        ST_RD_LO: begin
          if (mi.done) begin
            lim_lo_r <= mi.rdata;
            st_r <= ST_RD_HI;
            ms_start_r <= 1'b1;
            ms_addr_r <= ea_r - `SBX_LIM_HI_OFS;
          end
        end
        ST_RD_HI: begin
          if (mi.done) begin
            if ($signed(acv) < $signed(lim_lo_r) || $signed(acv) > $signed(mi.rdata)) begin
              st_r <= ST_IDLE;
              pc_r <= pc_r + `SBX_STEP;
            end else begin
              st_r <= ST_RD_TAB;
              ms_start_r <= 1'b1;
              ms_addr_r <= ea_r - lim_lo_r + acv;
            end
          end
        end
        ST_RD_TAB, ST_RD_IND: begin
          if (mi.done) begin
            if (st_r == ST_RD_TAB && mi.rdata == `SBX_NO_ENTRY) begin
              st_r <= ST_IDLE;
              pc_r <= pc_r + `SBX_STEP;
            end else if (mi.rdata[`SBX_IND_BIT]) begin
              st_r <= ST_RD_IND;
              ms_start_r <= 1'b1;
              ms_addr_r <= {1'b0, mi.rdata[14:0]};
            end else begin
              st_r <= ST_IDLE;
              pc_r <= mi.rdata;
            end
          end
        end
        ST_DEC_RD: begin
          if (mi.done) begin
            st_r <= ST_DEC_WR;
            dec_zero_r <= (mi.rdata == `SBX_STEP);
            ms_start_r <= 1'b1;
            ms_we_r <= 1'b1;
            ms_wdata_r <= mi.rdata - `SBX_STEP;
          end
        end
        ST_DEC_WR: begin
          if (mi.done) begin
            st_r <= ST_IDLE;
            lock_r <= 1'b0;
            ms_we_r <= 1'b0;
            pc_r <= pc_r + (dec_zero_r ? `SBX_SKIP : `SBX_STEP);
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  sbx_mem_port u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .mi(mi.port),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_lock(mem_lock),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .mem_ack(mem_ack)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic do_shift;
  logic [15:0] acs_v;
  assign do_shift = exec && (op_r == OP_DOUBLE_LOGICAL_SHIFT_OP) && double_logical_shift_op_hit;
  assign acs_v = ac_r[sel_s];

  sequence dec_read_done;
    (st_r == ST_DEC_RD) && mi.done;
  endsequence
  sequence dec_write_issued;
    mi.start && mi.we && mi.lock;
  endsequence

  shift_zero_a: assert property ((ac_r[sel_s][7:0] == 8'h00) |-> (sh_hi == ac_r[sel_d] && sh_lo == ac_r[sel_n]))
    else $error("zero count changed the operand");
  shift_clear_a: assert property (do_shift && ($signed(ac_r[sel_s][7:0]) > 31 || $signed(ac_r[sel_s][7:0]) < -31)
    |=> (ac_r[$past(sel_d)] == 16'h0000) && $stable(carry_r))
    else $error("oversized shift did not clear destination");
  shift_left_a: assert property (do_shift && ac_r[sel_s][7:0] == 8'h01 && sel_s != sel_d && sel_s != sel_n
    |=> ac_r[$past(sel_d)] == {$past(acv[14:0]), $past(ac_r[sel_n][15])} && $stable(acs_v))
    else $error("left shift by one wrong");
  bcd_upper_a: assert property (exec && op_r == OP_DSB |=> ac_r[$past(sel_d)][15:4] == $past(acv[15:4]))
    else $error("decimal subtract touched upper bits");
  halt_stop_a: assert property (exec && halt_cmd |=> halted && !io_strobe)
    else $error("halt form did not stop");
  io_out_a: assert property (exec && out_op && !halt_cmd && !bmc_hit && !map_hit
    |=> io_strobe && io_data == $past(acv) && io_dev == $past(dev_r) ##1 !io_strobe)
    else $error("output transfer not driven");
  lock_span_a: assert property ((st_r == ST_DEC_RD || st_r == ST_DEC_WR) |-> lock_r)
    else $error("lock dropped inside decrement");
  dec_write_a: assert property (dec_read_done |=> dec_write_issued and (mi.wdata == 16'($past(mi.rdata) - 16'h0001)))
    else $error("decrement write-back wrong");
  limit_fall_a: assert property (st_r == ST_RD_HI && mi.done && $signed(acv) < $signed(lim_lo_r)
    |=> st_r == ST_IDLE && pc_r == 16'($past(pc_r) + 16'h0001))
    else $error("below-limit dispatch did not fall through");
endmodule // sbx_exec_unit

//--- verif/sbx_mem_model.sv
// Behavioural main memory that answers after a settable delay
`timescale 1ns/1ps
module sbx_mem_model (
  input wire logic clk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  logic [15:0] mem [0:255];
  logic [1:0] lat = 2'h0;
  logic [1:0] cnt = 2'h0;
  wire hit = mem_req && !mem_ack && cnt == lat;
  initial mem_ack = 1'b0;
  initial mem_rdata = 16'h0000;
  // read word, take back written word
  always @(posedge clk) begin
    mem_ack <= hit;
    cnt <= hit ? 2'h0 : cnt + 2'(mem_req && !mem_ack);
    // Idle data keeps toggling so a stale word never passes
    mem_rdata <= hit ? mem[mem_addr[7:0]] : ~mem_rdata;
    if (hit && mem_we) mem[mem_addr[7:0]] <= mem_wdata;
  end
endmodule // sbx_mem_model

//--- verif/shift_bcd_dispatch_exec_unit_tb.sv
// Self-checking bench for the shift, decimal, output and dispatch unit
`timescale 1ns/1ps
`include "sbx_consts.svh"
module shift_bcd_dispatch_exec_unit_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rv;
  logic pready, pslverr, se, mem_req, mem_we, mem_lock, mem_ack, io_strobe, halted;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, io_data;
  logic [1:0] io_buf, io_func;
  logic [5:0] io_dev;
  int fails = 0;
  int total_checks = 0;
  int strobes = 0;
  int unlocked = 0;
  int bt[15] = '{16'h1234, 16'h1442, `SBX_ADDR_BLOW, 16'h8077, 16'h1443, `SBX_ADDR_BHIGH, 16'h0003, 16'h1443,
    `SBX_ADDR_BENTRY, 16'h0009, 16'h1444, `SBX_ADDR_BCOUNT, 16'h0ABC, 16'h3043, `SBX_ADDR_P31};
  int dt[10] = '{16'h0001, 16'h0050, 16'h0004, 16'h0051, 16'hFFFD, 16'h0052, 16'hFFFE, 16'h0053, 16'h0000, 16'h0077};
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    strobes <= strobes + int'(io_strobe === 1'b1);
    unlocked <= unlocked + int'(mem_req === 1'b1 && mem_we === 1'b1 && mem_lock !== 1'b1);
  end
  sbx_exec_unit DUT (.*);
  sbx_mem_model MEM (.*);
  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    chk(32'h0000_0000, 32'h0000_0001);
    results;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang;
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rv, e);
  endtask
  // Busy polling, since memory ops take as long as memory does
  task automatic cmd(input logic [31:0] c);
    int n;
    n = 0;
    apb(1'b1, `SBX_ADDR_CMD, c);
    do begin
      apb(1'b0, `SBX_ADDR_STAT, 32'h0000_0000);
      n++;
    end while (rv[`SBX_ST_BUSY] !== 1'b0 && n < 40);
    if (n >= 40) hang;
  endtask
  task automatic ac(input int i, input logic [31:0] d);
    apb(1'b1, `SBX_ADDR_AC0 + 12'(4 * i), d);
  endtask
  task automatic rac(input int i, input logic [31:0] e);
    rd(`SBX_ADDR_AC0 + 12'(4 * i), e);
  endtask
  task automatic sh(input int s, input int ins, input int c, input int a, input int ea, input int b, input int eb);
    apb(1'b1, `SBX_ADDR_INSTR, ins);
    ac(s, c);
    cmd(16'h0001);
    rac(a, ea);
    rac(b, eb);
  endtask
  task automatic bcd(input logic c, input int s, input int d, input int e, input logic ec);
    apb(1'b1, `SBX_ADDR_STAT, {28'h000_0000, 1'b1, 2'b00, c});
    ac(3, s);
    ac(2, d);
    cmd(16'h00B5);
    rac(2, e);
    rd(`SBX_ADDR_STAT, {31'h0000_0000, ec});
  endtask
  task automatic t_io;
    int n;
    int s;
    ac(1, 16'hBEEF);
    for (int b = 0; b < 3; b++) begin
      apb(1'b1, `SBX_ADDR_CMD, 32'h0000_4042 + b * 32'h0000_0101);
      n = 0;
      while (io_strobe !== 1'b1 && n < 8) begin
        @(posedge clk);
        n++;
      end
      if (n >= 8) hang;
      chk({io_buf, io_func, io_dev, io_data}, {b[1:0], b[1:0], 6'h10, 16'hBEEF});
    end
    rac(1, 16'hBEEF);
    s = strobes;
    for (int i = 0; i < 15; i += 3) begin
      ac(1, bt[i]);
      cmd(bt[i + 1]);
      rd(12'(bt[i + 2]), bt[i]);
    end
    cmd(16'hFC04);
    chk(halted, 1'b1);
    chk(strobes - s, 0);
    apb(1'b1, `SBX_ADDR_STAT, 16'h0000);
  endtask
  task automatic t_disp;
    MEM.mem[8'h3E] = 16'hFFFE;
    MEM.mem[8'h3F] = 16'h0003;
    MEM.mem[8'h40] = 16'hFFFF;
    MEM.mem[8'h42] = 16'h8044;
    MEM.mem[8'h43] = 16'h0050;
    MEM.mem[8'h44] = 16'h0077;
    apb(1'b1, `SBX_ADDR_EA, 16'h0040);
    for (int i = 0; i < 10; i += 2) begin
      ac(1, dt[i]);
      cmd(16'h0046);
      rd(`SBX_ADDR_PC, dt[i + 1]);
    end
    apb(1'b0, 12'h03C, 16'h0000);
    chk({se, rv[30:0]}, 32'h8000_0000);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    ac(1, 16'h14E5);
    ac(2, 16'h58D1);
    sh(0, 16'h8AC8, 16'h0001, 1, 16'h29CA, 2, 16'hB1A2);
    sh(0, 16'h8AC8, 16'h00FF, 1, 16'h14E5, 2, 16'h58D1);
    sh(0, 16'h8AC8, 16'hFF40, 1, 16'h0000, 2, 16'h58D1);
    sh(2, 16'hDAC8, 16'h0010, 3, 16'hFF40, 0, 16'h0000);
    sh(2, 16'h5AC8, 16'h0010, 3, 16'hFF40, 2, 16'h0010);
    rd(`SBX_ADDR_STAT, 16'h0008);
    bcd(1'b1, 16'h0007, 16'h1239, 16'h1232, 1'b1);
    bcd(1'b1, 16'h0005, 16'h4563, 16'h4568, 1'b0);
    bcd(1'b0, 16'h0002, 16'hABC5, 16'hABC2, 1'b1);
    t_io;
    MEM.mem[8'h20] = 16'h0001;
    MEM.mem[8'h21] = 16'h0005;
    apb(1'b1, `SBX_ADDR_EA, 16'h0020);
    apb(1'b1, `SBX_ADDR_PC, 16'h0100);
    cmd(16'h0007);
    rd(`SBX_ADDR_PC, 16'h0102);
    MEM.lat = 2'h3;
    apb(1'b1, `SBX_ADDR_EA, 16'h0021);
    cmd(16'h0008);
    rd(`SBX_ADDR_PC, 16'h0103);
    chk({MEM.mem[8'h20], MEM.mem[8'h21]}, 32'h0000_0004);
    chk(unlocked, 0);
    t_disp;
    results;
  end
endmodule // shift_bcd_dispatch_exec_unit_tb
